//--- include/adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;
  // Conversion-clock select encodings
  localparam logic [2:0] CLK_DIV2     = 3'h0;
  localparam logic [2:0] CLK_DIV8     = 3'h1;
  localparam logic [2:0] CLK_DIV32    = 3'h2;
  localparam logic [2:0] CLK_DIV4     = 3'h4;
  localparam logic [2:0] CLK_DIV16    = 3'h5;
  localparam logic [2:0] CLK_DIV64    = 3'h6;
  localparam logic [1:0] CLK_RC_LOW   = 2'h3;
  // Half bit-period lengths in system cycles, minus one
  localparam logic [4:0] HALF_DIV2    = 5'h00;
  localparam logic [4:0] HALF_DIV4    = 5'h01;
  localparam logic [4:0] HALF_DIV8    = 5'h03;
  localparam logic [4:0] HALF_DIV16   = 5'h07;
  localparam logic [4:0] HALF_DIV32   = 5'h0F;
  localparam logic [4:0] HALF_DIV64   = 5'h1F;
  // Channel codes that have an input behind them
  localparam logic [4:0] CH_PIN_LAST_LOW  = 5'h04;
  localparam logic [4:0] CH_PIN_FIRST_HI  = 5'h08;
  localparam logic [4:0] CH_PIN_LAST_HI   = 5'h0D;
  localparam logic [4:0] CH_TEMPERATURE   = 5'h1D;
  localparam logic [4:0] CH_FIXED_REF     = 5'h1F;
  // Positive reference encodings
  localparam logic [1:0] PREF_SUPPLY  = 2'h0;
  localparam logic [1:0] PREF_PIN     = 2'h2;
  // Conversion timing: 11.5 bit periods, counted in half periods
  localparam int          RESULT_BITS     = 10;
  localparam logic [4:0]  ACQ_LAST_HALF   = 5'h02;
  localparam logic [4:0]  CONV_LAST_HALF  = 5'h16;
  localparam logic [3:0]  MSB_INDEX       = 4'h9;
  localparam logic [9:0]  MSB_TRIAL       = 10'h200;
  localparam logic [9:0]  RESULT_RESET    = 10'h000;
  localparam logic [7:0]  RESULT_REG_RESET = 8'h00;
  // Temperature sensor settling time
  localparam int          CLOCK_MHZ            = 250;
  localparam int          SENSOR_SETTLE_US     = 200;
  localparam int          SENSOR_SETTLE_CYCLES = SENSOR_SETTLE_US * CLOCK_MHZ;
  localparam int          SETTLE_W             = 17;
  typedef enum logic [1:0] {IDLE, START_WAIT, ACQUIRE, CONVERT} conv_state_t;
endpackage : adc_seq_pkg
`default_nettype wire

//--- rtl/conversion_divider.sv
`timescale 1ns/1ps
`default_nettype none
module conversion_divider
  import adc_seq_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       run_in,
  input  wire logic [2:0] select_in,
  input  wire logic       rc_tick_in,
  output logic            half_tick_out
);
  typedef struct packed {
    logic [4:0] count;
  } div_state_t;

  div_state_t state_q;
  div_state_t next_state;
  logic [4:0] limit;
  logic       rc_selected;

  always_comb begin
    unique case (select_in)
      CLK_DIV2:  limit = HALF_DIV2;
      CLK_DIV4:  limit = HALF_DIV4;
      CLK_DIV8:  limit = HALF_DIV8;
      CLK_DIV16: limit = HALF_DIV16;
      CLK_DIV32: limit = HALF_DIV32;
      CLK_DIV64: limit = HALF_DIV64;
      default:   limit = HALF_DIV2;
    endcase
  end

  assign rc_selected = (select_in[1:0] == CLK_RC_LOW);

  always_comb begin
    next_state = state_q;
    if (!run_in || rc_selected || state_q.count == limit) begin
      next_state.count = 5'h00;
    end else begin
      next_state.count = state_q.count + 5'h01;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= '0;
    end else begin
      state_q <= next_state;
    end
  end

  assign half_tick_out = run_in && (rc_selected ? rc_tick_in : (state_q.count == limit));
endmodule : conversion_divider
`default_nettype wire

//--- rtl/adc_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module adc_sequencer
  import adc_seq_pkg::*;
#(
  parameter int SETTLE_CYCLES = SENSOR_SETTLE_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       converter_enable_in,
  input  wire logic       go_set_in,
  input  wire logic       go_clear_in,
  input  wire logic [4:0] channel_select_field_in,
  input  wire logic [1:0] positive_reference_field_in,
  input  wire logic [2:0] conversion_clock_select_in,
  input  wire logic       result_format_select_in,
  input  wire logic       sensor_enable_in,
  input  wire logic       sensor_range_select_in,
  input  wire logic       flag_clear_in,
  input  wire logic       conversion_irq_enable_in,
  input  wire logic       global_irq_enable_in,
  input  wire logic       peripheral_irq_enable_in,
  input  wire logic       sleep_in,
  input  wire logic       instruction_step_in,
  input  wire logic       rc_tick_in,
  input  wire logic       comparator_in,
  output logic            sensor_power_out,
  output logic            sensor_high_range_out,
  output logic [4:0]      mux_select_out,
  output logic            channel_valid_out,
  output logic            reference_pin_out,
  output logic            sample_out,
  output logic [9:0]      dac_code_out,
  output logic            busy_out,
  output logic            converter_active_out,
  output logic            conversion_complete_flag_out,
  output logic            irq_out,
  output logic            wake_out,
  output logic            vector_out,
  output logic            sensor_ready_out,
  output logic [7:0]      result_high_reg_out,
  output logic [7:0]      result_low_reg_out
);
  typedef struct packed {
    conv_state_t          phase;
    logic [4:0]           half_count;
    logic [3:0]           bit_index;
    logic [9:0]           sar;
    logic [9:0]           trial;
    logic                 flag;
    logic                 sleep_off;
    logic                 power;
    logic                 high_range;
    logic                 ref_pin;
    logic [4:0]           mux;
    logic [SETTLE_W-1:0]  settle;
    logic [7:0]           res_high;
    logic [7:0]           res_low;
  } seq_state_t;

  localparam logic [SETTLE_W-1:0] SETTLE_MAX = SETTLE_W'(SETTLE_CYCLES);

  seq_state_t state_q;
  seq_state_t next_state;
  logic       half_tick;
  logic       running;
  logic       rc_selected;
  logic       done;
  logic       abort;
  logic       early_stop;

  ////////////////////////////////////////////////////////////////////////////
  // Pad unconverted bits with the last bit decided
  function automatic logic [9:0] pad_partial(input logic [9:0] sar,
                                             input logic [3:0] idx,
                                             input logic       started);
    logic       last;
    logic [9:0] out;
    last = 1'b0;
    out  = sar;
    if (started && idx < MSB_INDEX) begin
      last = sar[idx + 4'h1];
    end
    for (int i = 0; i < RESULT_BITS; i++) begin
      if (4'(i) <= idx) begin
        out[i] = last;
      end
    end
    return out;
  endfunction : pad_partial

  function automatic logic [15:0] justify(input logic [9:0] r, input logic right);
    return right ? {6'h00, r} : {r, 6'h00};
  endfunction : justify

  ////////////////////////////////////////////////////////////////////////////
  assign rc_selected = (conversion_clock_select_in[1:0] == CLK_RC_LOW);
  assign running     = (state_q.phase == ACQUIRE) || (state_q.phase == CONVERT);

  conversion_divider u_divider (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .run_in        (running),
    .select_in     (conversion_clock_select_in),
    .rc_tick_in    (rc_tick_in),
    .half_tick_out (half_tick)
  );

  assign done = (state_q.phase == CONVERT) && half_tick && (state_q.half_count == CONV_LAST_HALF);
  assign abort = (state_q.phase != IDLE)
              && (!converter_enable_in || (sleep_in && !rc_selected));
  assign early_stop = running && go_clear_in && !abort;

  always_comb begin
    logic [15:0] packed_res;
    packed_res = 16'h0000;
    next_state = state_q;
    next_state.power      = sensor_enable_in;
    next_state.high_range = sensor_range_select_in;
    next_state.ref_pin    = (positive_reference_field_in == PREF_PIN);
    next_state.mux        = channel_select_field_in;
    if (!sleep_in) begin
      next_state.sleep_off = 1'b0;
    end
    if (channel_select_field_in != CH_TEMPERATURE) begin
      next_state.settle = '0;
    end else if (state_q.settle != SETTLE_MAX) begin
      next_state.settle = state_q.settle + SETTLE_W'(1);
    end
    if (flag_clear_in) begin
      next_state.flag = 1'b0;
    end
    unique case (state_q.phase)
      IDLE: begin
        if (converter_enable_in && go_set_in && !state_q.sleep_off) begin
          next_state.half_count = 5'h00;
          next_state.bit_index  = MSB_INDEX;
          next_state.sar        = RESULT_RESET;
          next_state.trial      = RESULT_RESET;
          next_state.phase = rc_selected ? START_WAIT : ACQUIRE;
        end
      end
      START_WAIT: begin
        if (go_clear_in) begin
          next_state.phase = IDLE;
        end else if (instruction_step_in) begin
          next_state.phase = ACQUIRE;
        end
      end
      ACQUIRE: begin
        if (half_tick) begin
          next_state.half_count = state_q.half_count + 5'h01;
          if (state_q.half_count == ACQ_LAST_HALF) begin
            next_state.phase = CONVERT;
            next_state.trial = MSB_TRIAL;
          end
        end
      end
      CONVERT: begin
        if (half_tick) begin
          next_state.half_count = state_q.half_count + 5'h01;
          if (!state_q.half_count[0]) begin
            next_state.sar[state_q.bit_index] = comparator_in;
            if (state_q.bit_index != 4'h0) begin
              next_state.bit_index = state_q.bit_index - 4'h1;
              next_state.trial = (state_q.trial & ~(10'h001 << state_q.bit_index))
                               | (comparator_in ? (10'h001 << state_q.bit_index) : 10'h000)
                               | (10'h001 << (state_q.bit_index - 4'h1));
            end
          end
        end
      end
    endcase
    if (done && !abort) begin
      packed_res = justify({state_q.sar[9:1], comparator_in}, result_format_select_in);
      next_state.res_high = packed_res[15:8];
      next_state.res_low  = packed_res[7:0];
      next_state.phase    = IDLE;
      next_state.flag     = 1'b1;
      next_state.settle   = '0;
      // Sleep conversion without wake turns off
      if (sleep_in && !conversion_irq_enable_in) begin
        next_state.sleep_off = 1'b1;
      end
    end else if (early_stop) begin
      packed_res = justify(pad_partial(state_q.sar, state_q.bit_index,
                                       state_q.phase == CONVERT),
                           result_format_select_in);
      next_state.res_high = packed_res[15:8];
      next_state.res_low  = packed_res[7:0];
      next_state.phase    = IDLE;
    end else if (abort) begin
      next_state.phase     = IDLE;
      next_state.sleep_off = sleep_in;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q          <= '0;
      state_q.phase    <= IDLE;
      state_q.res_high <= RESULT_REG_RESET;
      state_q.res_low  <= RESULT_REG_RESET;
    end else begin
      state_q <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign sensor_power_out      = state_q.power;
  assign sensor_high_range_out = state_q.high_range;
  assign reference_pin_out     = state_q.ref_pin;
  assign mux_select_out        = state_q.mux;
  assign channel_valid_out = (state_q.mux <= CH_PIN_LAST_LOW)
                          || (state_q.mux >= CH_PIN_FIRST_HI && state_q.mux <= CH_PIN_LAST_HI)
                          || (state_q.mux == CH_TEMPERATURE) || (state_q.mux == CH_FIXED_REF);
  assign sample_out            = (state_q.phase != CONVERT);
  assign dac_code_out          = state_q.trial;
  assign busy_out              = (state_q.phase != IDLE);
  assign converter_active_out  = converter_enable_in && !state_q.sleep_off;
  assign conversion_complete_flag_out = state_q.flag;
  assign irq_out   = state_q.flag && conversion_irq_enable_in;
  // wake; in-line instruction runs before vectoring
  assign wake_out  = irq_out && sleep_in;
  assign vector_out = irq_out && !sleep_in && global_irq_enable_in
                   && peripheral_irq_enable_in;
  assign sensor_ready_out    = (state_q.settle == SETTLE_MAX);
  assign result_high_reg_out = state_q.res_high;
  assign result_low_reg_out  = state_q.res_low;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sensor_power_a: assert property (sensor_power_out == $past(sensor_enable_in))
    else $error("sensor power does not follow enable");
  conv_length_a: assert property (done |-> state_q.bit_index == 4'h0)
    else $error("conversion ended before the last bit");
  flag_set_a: assert property (done && !abort |=> conversion_complete_flag_out && !busy_out)
    else $error("completion did not flag and clear busy");
  flag_hold_a: assert property (conversion_complete_flag_out && !flag_clear_in
                                |=> conversion_complete_flag_out)
    else $error("flag cleared without software");
  irq_gate_a: assert property (irq_out |-> conversion_complete_flag_out
                               && conversion_irq_enable_in)
    else $error("request without flag and enable");
  vector_gate_a: assert property (vector_out |-> global_irq_enable_in
                                  && peripheral_irq_enable_in)
    else $error("vector without both enables");
  rc_wait_a: assert property (state_q.phase == IDLE && converter_enable_in && go_set_in
                              && rc_selected && !state_q.sleep_off && !sleep_in
                              |=> state_q.phase == START_WAIT)
    else $error("RC start did not wait");
  sleep_abort_a: assert property (busy_out && sleep_in && !rc_selected |=> !busy_out)
    else $error("conversion kept running in Sleep");
  right_pad_a: assert property (done && !abort && result_format_select_in
                                |=> result_high_reg_out[7:2] == 6'h00)
    else $error("upper result bits not zeroed");
  left_pad_a: assert property (done && !abort && !result_format_select_in
                               |=> result_low_reg_out[5:0] == 6'h00)
    else $error("lower result bits not zeroed");
  idle_tick_a: assert property (state_q.phase == IDLE |-> !half_tick)
    else $error("divider ticks while idle");

  // Configuration outputs lag their inputs by one cycle
  range_follow_a: assert property (sensor_high_range_out == $past(sensor_range_select_in))
    else $error("sensor range does not follow select");
  mux_follow_a: assert property (mux_select_out == $past(channel_select_field_in))
    else $error("mux does not follow channel field");
  ref_follow_a: assert property (reference_pin_out == ($past(positive_reference_field_in)
                                 == PREF_PIN))
    else $error("reference choice does not follow field");
  // Early stop leaves the flag alone unless the conversion completes in the same cycle
  stop_idle_a: assert property (early_stop |=> !busy_out)
    else $error("early stop left the converter busy");
  stop_flag_a: assert property (early_stop && !done && !flag_clear_in
                                |=> $stable(conversion_complete_flag_out))
    else $error("early stop changed the flag");
  // Stored words carry the full decided code
  right_word_a: assert property (done && !abort && result_format_select_in
                                 |=> {result_high_reg_out[1:0], result_low_reg_out} == state_q.sar)
    else $error("right-justified result misplaced");
  left_word_a: assert property (done && !abort && !result_format_select_in
                                |=> {result_high_reg_out, result_low_reg_out[7:6]} == state_q.sar)
    else $error("left-justified result misplaced");
  wait_hold_a: assert property (state_q.phase == START_WAIT && !go_clear_in && !instruction_step_in
                                && !abort |=> state_q.phase == START_WAIT)
    else $error("RC start left the wait early");
  sleep_off_a: assert property (busy_out && sleep_in && !rc_selected |=> !converter_active_out)
    else $error("converter still active after Sleep abort");
  flag_wake_a: assert property (irq_out && sleep_in |-> wake_out)
    else $error("enabled completion did not wake");

  done_c: cover property (done && !abort);
  early_c: cover property (early_stop);
  sleep_c: cover property (busy_out && sleep_in && !rc_selected);
  wake_c: cover property (wake_out);
  rc_sleep_c: cover property (done && !abort && sleep_in);
endmodule : adc_sequencer
`default_nettype wire

//--- bench/tb_adc_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s: expected %0h seen %0h", nm, (e), (g)); end end
module tb_adc_sequencer
  import adc_seq_pkg::*;
;
  localparam int SETTLE = 20;
  logic       clk_in, reset_in, converter_enable_in, go_set_in, go_clear_in;
  logic [4:0] channel_select_field_in;
  logic [1:0] positive_reference_field_in;
  logic [2:0] conversion_clock_select_in;
  logic       result_format_select_in, sensor_enable_in, sensor_range_select_in;
  logic       flag_clear_in, conversion_irq_enable_in, global_irq_enable_in;
  logic       peripheral_irq_enable_in, sleep_in, instruction_step_in;
  logic       rc_tick_in, comparator_in;
  logic       sensor_power_out, sensor_high_range_out, channel_valid_out;
  logic       reference_pin_out, sample_out, busy_out, converter_active_out;
  logic       conversion_complete_flag_out, irq_out, wake_out, vector_out;
  logic       sensor_ready_out;
  logic [4:0] mux_select_out;
  logic [9:0] dac_code_out, tgt, keep;
  logic [7:0] result_high_reg_out, result_low_reg_out;
  int         error_cnt, tests_run;
  int         n;
  logic [2:0] divs [6];

  adc_sequencer #(.SETTLE_CYCLES(SETTLE)) uut (
    .clk_in, .reset_in, .converter_enable_in, .go_set_in, .go_clear_in,
    .channel_select_field_in, .positive_reference_field_in,
    .conversion_clock_select_in, .result_format_select_in, .sensor_enable_in,
    .sensor_range_select_in, .flag_clear_in, .conversion_irq_enable_in,
    .global_irq_enable_in, .peripheral_irq_enable_in, .sleep_in,
    .instruction_step_in, .rc_tick_in, .comparator_in, .sensor_power_out,
    .sensor_high_range_out, .mux_select_out, .channel_valid_out,
    .reference_pin_out, .sample_out, .dac_code_out, .busy_out,
    .converter_active_out, .conversion_complete_flag_out, .irq_out, .wake_out,
    .vector_out, .sensor_ready_out, .result_high_reg_out, .result_low_reg_out);

  ////////////////////////////////////////////////////////////////////////////
  always #2 clk_in = ~clk_in;

  // Analog input modelled as a fixed level against the trial code
  always @(posedge clk_in) begin
    #1;
    comparator_in = (tgt >= dac_code_out);
  end

  task automatic step(input int k);
    repeat (k) begin
      @(posedge clk_in);
      #1;
    end
  endtask : step

  task automatic pulse_go();
    go_set_in = 1'b1;
    step(1);
    go_set_in = 1'b0;
  endtask : pulse_go

  task automatic clear_flag();
    flag_clear_in = 1'b1;
    step(1);
    flag_clear_in = 1'b0;
  endtask : clear_flag

  task automatic wait_idle(input int lim);
    n = 0;
    while (busy_out === 1'b1 && n < lim) begin
      n++;
      step(1);
    end
  endtask : wait_idle

  task automatic check_result(input logic [9:0] r);
    logic [15:0] e;
    e = result_format_select_in ? {6'h00, r} : {r, 6'h00};
    `CHK("result_high", e[15:8], result_high_reg_out)
    `CHK("result_low", e[7:0], result_low_reg_out)
  endtask : check_result

  function automatic logic [9:0] partial(input logic [9:0] t, input int d);
    logic [9:0] r;
    r = t;
    for (int i = 0; i < 10 - d; i++) r[i] = t[10 - d];
    return r;
  endfunction : partial

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end

  initial begin
    divs = '{CLK_DIV2, CLK_DIV4, CLK_DIV8, CLK_DIV16, CLK_DIV32, CLK_DIV64};
    clk_in = 1'b0; reset_in = 1'b1; converter_enable_in = 1'b1;
    go_set_in = 1'b0; go_clear_in = 1'b0; channel_select_field_in = 5'h00;
    positive_reference_field_in = PREF_SUPPLY; conversion_clock_select_in = CLK_DIV2;
    result_format_select_in = 1'b1; sensor_enable_in = 1'b0;
    sensor_range_select_in = 1'b0; flag_clear_in = 1'b0; sleep_in = 1'b0;
    conversion_irq_enable_in = 1'b0; global_irq_enable_in = 1'b0;
    peripheral_irq_enable_in = 1'b0; instruction_step_in = 1'b0;
    rc_tick_in = 1'b0; comparator_in = 1'b0; tgt = 10'h000;
    error_cnt = 0; tests_run = 0;
    void'($urandom(32'h338CD4E6));
    step(20);
    `CHK("busy", 1'b0, busy_out)
    `CHK("flag", 1'b0, conversion_complete_flag_out)
    `CHK("sample", 1'b1, sample_out)
    reset_in = 1'b0;
    $display("test reset done");

    for (int i = 0; i < 24; i++) begin
      logic [4:0] ch;
      ch = (i == 0) ? CH_TEMPERATURE : (i == 1) ? CH_FIXED_REF : 5'($urandom);
      channel_select_field_in = ch;
      sensor_enable_in = 1'($urandom);
      sensor_range_select_in = 1'($urandom);
      positive_reference_field_in = $urandom % 2 ? PREF_PIN : PREF_SUPPLY;
      step(1);
      `CHK("sensor_power", sensor_enable_in, sensor_power_out)
      `CHK("high_range", sensor_range_select_in, sensor_high_range_out)
      `CHK("mux", ch, mux_select_out)
      `CHK("ref_pin", positive_reference_field_in == PREF_PIN, reference_pin_out)
      `CHK("ch_valid", ch <= CH_PIN_LAST_LOW || (ch >= CH_PIN_FIRST_HI &&
           ch <= CH_PIN_LAST_HI) || ch == CH_TEMPERATURE || ch == CH_FIXED_REF,
           channel_valid_out)
    end
    step(SETTLE);
    $display("test configuration done");

    for (int i = 0; i < 8; i++) begin
      conversion_clock_select_in = divs[i % 6];
      result_format_select_in = 1'($urandom);
      tgt = (i == 6) ? 10'h3FF : (i == 7) ? 10'h000 : 10'($urandom);
      clear_flag();
      pulse_go();
      `CHK("busy_start", 1'b1, busy_out)
      wait_idle(4000);
      `CHK("bit_periods", 23 << (i % 6), n)
      `CHK("flag_set", 1'b1, conversion_complete_flag_out)
      check_result(tgt);
    end
    $display("test divided conversions done");

    for (int i = 0; i < 16; i++) begin
      {conversion_irq_enable_in, global_irq_enable_in} = i[3:2];
      {peripheral_irq_enable_in, sleep_in} = i[1:0];
      step(1);
      `CHK("flag_hold", 1'b1, conversion_complete_flag_out)
      `CHK("irq", i[3], irq_out)
      `CHK("wake", i[3] & i[0], wake_out)
      `CHK("vector", i[3] & ~i[0] & i[2] & i[1], vector_out)
    end
    sleep_in = 1'b0;
    clear_flag();
    `CHK("flag_clr", 1'b0, conversion_complete_flag_out)
    `CHK("irq_clr", 1'b0, irq_out)
    $display("test interrupts done");

    for (int i = 0; i < 2; i++) begin
      conversion_clock_select_in = i ? 3'h7 : {1'b0, CLK_RC_LOW};
      conversion_irq_enable_in = 1'b1;
      tgt = 10'($urandom);
      pulse_go();
      sleep_in = 1'(i);
      step(5);
      `CHK("rc_hold", 1'b1, busy_out)
      instruction_step_in = 1'b1;
      step(1);
      instruction_step_in = 1'b0;
      repeat (23) begin
        rc_tick_in = 1'b1;
        step(1);
        rc_tick_in = 1'b0;
        step(2);
      end
      wait_idle(4);
      `CHK("rc_done", 1'b0, busy_out)
      `CHK("rc_flag", 1'b1, conversion_complete_flag_out)
      `CHK("rc_wake", 1'(i), wake_out)
      check_result(tgt);
      sleep_in = 1'b0;
      conversion_irq_enable_in = 1'b0;
      clear_flag();
    end
    $display("test rc conversions done");

    conversion_clock_select_in = CLK_DIV8;
    keep = 10'($urandom);
    tgt = keep;
    pulse_go();
    wait_idle(4000);
    clear_flag();
    tgt = ~keep;
    pulse_go();
    step(30);
    sleep_in = 1'b1;
    step(1);
    `CHK("sleep_abort", 1'b0, busy_out)
    `CHK("slept_off", 1'b0, converter_active_out)
    step(3);
    `CHK("abort_flag", 1'b0, conversion_complete_flag_out)
    check_result(keep);
    sleep_in = 1'b0;
    step(1);
    `CHK("awake", 1'b1, converter_active_out)
    $display("test sleep abort done");

    conversion_clock_select_in = CLK_DIV4;
    for (int d = 1; d < 10; d += 4) begin
      logic [9:0] prev;
      tgt = 10'($urandom);
      pulse_go();
      n = 0;
      while (dac_code_out !== MSB_TRIAL && n < 100) begin
        n++;
        step(1);
      end
      prev = dac_code_out;
      `CHK("sample_held", 1'b0, sample_out)
      for (int k = 0; k < d && n < 400; n++) begin
        step(1);
        if (dac_code_out !== prev) k++;
        prev = dac_code_out;
      end
      go_clear_in = 1'b1;
      step(1);
      go_clear_in = 1'b0;
      wait_idle(4);
      `CHK("stop_busy", 1'b0, busy_out)
      `CHK("stop_flag", 1'b0, conversion_complete_flag_out)
      check_result(partial(tgt, d));
    end
    $display("test early stop done");

    converter_enable_in = 1'b0;
    pulse_go();
    `CHK("refused", 1'b0, busy_out)
    converter_enable_in = 1'b1;
    channel_select_field_in = 5'h00;
    step(1);
    channel_select_field_in = CH_TEMPERATURE;
    step(SETTLE / 2);
    `CHK("settling", 1'b0, sensor_ready_out)
    step(SETTLE);
    `CHK("settled", 1'b1, sensor_ready_out)
    pulse_go();
    wait_idle(4000);
    `CHK("respaced", 1'b0, sensor_ready_out)
    $display("test sensor settle done");
    final_report();
  end
endmodule : tb_adc_sequencer
`default_nettype wire
